// ===== src/amdec_defs.svh
// Operation
// [RULE_01] immediate operand follows opcode, pc plus two
// [RULE_02] direct: high zero, low next byte, pc+2
// [RULE_03] extended: two address bytes, pc plus three
// [RULE_04] no-offset indexed: index low, one byte
// [RULE_05] 8-bit offset: index plus offset, carry high
// [RULE_06] 16-bit offset: carry into high offset byte
// [RULE_07] index register never modified by addressing
// [RULE_08] relative branch: pc+2+signed offset if taken
// [RULE_09] bit set/clear: two bytes, direct page
// [RULE_10] bit test branch: pc+3+signed third byte
// [RULE_11] register/memory mode in high nibble
// [RULE_12] register/memory cycles 2,3,4,3,4,5
// [RULE_13] read/modify/write mode in high nibble
// [RULE_14] modify cycles 3,5,5,6 with write back
// [RULE_15] test op no write back, 3,4,4,5 cycles
`ifndef AMDEC_DEFS_SVH
`define AMDEC_DEFS_SVH
`define AMDEC_HI_IMM 4'h_A
`define AMDEC_HI_DIR 4'h_B
`define AMDEC_HI_EXT 4'h_C
`define AMDEC_HI_IX2 4'h_D
`define AMDEC_HI_IX1 4'h_E
`define AMDEC_HI_IX0 4'h_F
`define AMDEC_HI_RDIR 4'h_3
`define AMDEC_HI_RINA 4'h_4
`define AMDEC_HI_RINX 4'h_5
`define AMDEC_HI_RIX1 4'h_6
`define AMDEC_HI_RIX0 4'h_7
`define AMDEC_HI_BTB 4'h_0
`define AMDEC_HI_BSC 4'h_1
`define AMDEC_HI_REL 4'h_2
`define AMDEC_LO_STA 4'h_7
`define AMDEC_LO_STX 4'h_F
`define AMDEC_LO_JMP 4'h_C
`define AMDEC_LO_JSR 4'h_D
`define AMDEC_LO_TST 4'h_D
`define AMDEC_ZERO8 8'h_00
`define AMDEC_PC_ONE 16'h_0001
`define AMDEC_PC_TWO 16'h_0002
`define AMDEC_PC_THREE 16'h_0003
`define AMDEC_CYC_2 4'h_2
`define AMDEC_CYC_3 4'h_3
`define AMDEC_CYC_4 4'h_4
`define AMDEC_CYC_5 4'h_5
`define AMDEC_CYC_6 4'h_6
`endif

// ===== src/amdec_pkg.sv
package amdec_pkg;
  // addressing mode decoded from the opcode
  typedef enum logic [3:0] {
    AMDEC_M_INH, AMDEC_M_IMM, AMDEC_M_DIR, AMDEC_M_EXT, AMDEC_M_IX0,
    AMDEC_M_IX1, AMDEC_M_IX2, AMDEC_M_REL, AMDEC_M_BSC, AMDEC_M_BTB,
    AMDEC_M_BAD
  } amdec_mode_t;
  // instruction fetched: opcode plus the bytes after it
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [7:0] index;
    logic [15:0] pc;
    logic cond_true;
    logic [7:0] test_data;
  } amdec_req_t;
  // decoded result
  typedef struct packed {
    amdec_mode_t mode;
    logic [15:0] eff_addr;
    logic [15:0] next_pc;
    logic [3:0] cycles;
    logic write_back;
    logic [2:0] bit_num;
    logic illegal;
  } amdec_res_t;
endpackage : amdec_pkg

// ===== src/amdec_mode.sv
`timescale 1ns/1ps
`include "amdec_defs.svh"
// combinational opcode classifier: mode and cycle count
module amdec_mode import amdec_pkg::*; (
  input wire logic [7:0] opcode,
  output amdec_mode_t mode,
  output logic [3:0] cycles,
  output logic write_back,
  output logic illegal
);
  logic [3:0] hi;
  logic [3:0] lo;
  logic is_st;
  logic is_tst;
  assign hi = opcode[7:4];
  assign lo = opcode[3:0];
  assign is_st = (lo == `AMDEC_LO_STA) || (lo == `AMDEC_LO_STX);
  assign is_tst = (lo == `AMDEC_LO_TST);

  // mode and timing from the high nibble
  always_comb begin
    mode = AMDEC_M_INH;
    cycles = `AMDEC_CYC_2;
    write_back = 1'b0;
    illegal = 1'b0;
    unique case (hi)
      // [RULE_11] register/memory modes
      `AMDEC_HI_IMM: begin
        mode = AMDEC_M_IMM;
        // stores and jumps have no immediate form
        illegal = is_st || (lo == `AMDEC_LO_JMP) || (lo == `AMDEC_LO_JSR);
        // [RULE_12] immediate timing
        cycles = `AMDEC_CYC_2;
      end
      `AMDEC_HI_DIR: begin
        mode = AMDEC_M_DIR;
        cycles = `AMDEC_CYC_3;
      end
      `AMDEC_HI_EXT: begin
        mode = AMDEC_M_EXT;
        cycles = `AMDEC_CYC_4;
      end
      `AMDEC_HI_IX0: begin
        mode = AMDEC_M_IX0;
        cycles = `AMDEC_CYC_3;
      end
      `AMDEC_HI_IX1: begin
        mode = AMDEC_M_IX1;
        cycles = `AMDEC_CYC_4;
      end
      `AMDEC_HI_IX2: begin
        mode = AMDEC_M_IX2;
        cycles = `AMDEC_CYC_5;
      end
      // [RULE_13] read/modify/write modes
      `AMDEC_HI_RINA, `AMDEC_HI_RINX: begin
        mode = AMDEC_M_INH;
        // [RULE_14] [RULE_15] inherent timing
        cycles = `AMDEC_CYC_3;
        write_back = !is_tst;
      end
      `AMDEC_HI_RDIR, `AMDEC_HI_RIX0: begin
        mode = (hi == `AMDEC_HI_RDIR) ? AMDEC_M_DIR : AMDEC_M_IX0;
        // [RULE_15] test skips the write cycle
        cycles = is_tst ? `AMDEC_CYC_4 : `AMDEC_CYC_5;
        write_back = !is_tst;
      end
      `AMDEC_HI_RIX1: begin
        mode = AMDEC_M_IX1;
        // [RULE_14] offset modify timing
        cycles = is_tst ? `AMDEC_CYC_5 : `AMDEC_CYC_6;
        write_back = !is_tst;
      end
      `AMDEC_HI_REL: begin
        mode = AMDEC_M_REL;
        cycles = `AMDEC_CYC_3;
      end
      `AMDEC_HI_BSC: begin
        mode = AMDEC_M_BSC;
        cycles = `AMDEC_CYC_5;
        write_back = 1'b1;
      end
      `AMDEC_HI_BTB: begin
        mode = AMDEC_M_BTB;
        cycles = `AMDEC_CYC_5;
      end
      default: begin
        // control group falls back to inherent, two cycles
        mode = AMDEC_M_INH;
      end
    endcase
  end
endmodule : amdec_mode

// ===== src/amdec_top.sv
`timescale 1ns/1ps
`include "amdec_defs.svh"
// address mode decoder: one request per valid cycle, result one cycle later
module amdec_top import amdec_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input amdec_req_t req,
  output logic res_valid,
  output amdec_res_t res,
  output logic [7:0] index_out
);
  ////////////////////////////////////////////////////////////////////////
  // opcode classification
  amdec_mode_t mode;
  logic [3:0] cycles;
  logic write_back;
  logic illegal;

  amdec_mode u_mode (
    .opcode(req.opcode),
    .mode(mode),
    .cycles(cycles),
    .write_back(write_back),
    .illegal(illegal)
  );

  ////////////////////////////////////////////////////////////////////////
  // address arithmetic
  logic [8:0] sum_lo; // index plus an offset byte, carry in bit 8
  logic [7:0] off_sel; // offset byte added to index
  logic [15:0] rel_base; // pc past the instruction
  logic [15:0] rel_off; // sign-extended displacement
  logic bit_hit; // bit test result
  amdec_res_t nxt_res;
  amdec_res_t res_ff;
  logic res_valid_ff;
  logic nxt_res_valid;
  logic [7:0] index_ff;
  logic [7:0] nxt_index;

  // next result from the request
  always_comb begin
    off_sel = (mode == AMDEC_M_IX2) ? req.byte2 : req.byte1;
    sum_lo = {1'b0, req.index} + {1'b0, off_sel};
    rel_base = req.pc + `AMDEC_PC_TWO;
    rel_off = {{8{req.byte1[7]}}, req.byte1};
    bit_hit = (req.test_data[req.opcode[3:1]] == ~req.opcode[0]);
    nxt_res = '0;
    nxt_res.mode = illegal ? AMDEC_M_BAD : mode;
    nxt_res.cycles = cycles;
    nxt_res.write_back = write_back;
    nxt_res.illegal = illegal;
    nxt_res.bit_num = req.opcode[3:1];
    nxt_res.next_pc = req.pc + `AMDEC_PC_ONE;
    unique case (mode)
      AMDEC_M_IMM: begin
        // [RULE_01] operand at pc+1
        nxt_res.eff_addr = req.pc + `AMDEC_PC_ONE;
        nxt_res.next_pc = req.pc + `AMDEC_PC_TWO;
      end
      AMDEC_M_DIR, AMDEC_M_BSC: begin
        // [RULE_02] [RULE_09] direct page address
        nxt_res.eff_addr = {`AMDEC_ZERO8, req.byte1};
        nxt_res.next_pc = req.pc + `AMDEC_PC_TWO;
      end
      AMDEC_M_EXT: begin
        // [RULE_03] full address, high byte first
        nxt_res.eff_addr = {req.byte1, req.byte2};
        nxt_res.next_pc = req.pc + `AMDEC_PC_THREE;
      end
      AMDEC_M_IX0: begin
        // [RULE_04] index alone in page zero
        nxt_res.eff_addr = {`AMDEC_ZERO8, req.index};
        nxt_res.next_pc = req.pc + `AMDEC_PC_ONE;
      end
      AMDEC_M_IX1: begin
        // [RULE_05] carry becomes the high byte
        nxt_res.eff_addr = {7'h_00, sum_lo};
        nxt_res.next_pc = req.pc + `AMDEC_PC_TWO;
      end
      AMDEC_M_IX2: begin
        // [RULE_06] carry ripples into the high offset byte
        nxt_res.eff_addr = {req.byte1 + {7'h_00, sum_lo[8]}, sum_lo[7:0]};
        nxt_res.next_pc = req.pc + `AMDEC_PC_THREE;
      end
      AMDEC_M_REL: begin
        // [RULE_08] taken branch adds signed offset
        nxt_res.eff_addr = rel_base + rel_off;
        nxt_res.next_pc = req.cond_true ? rel_base + rel_off : rel_base;
      end
      AMDEC_M_BTB: begin
        // [RULE_10] test then branch past three bytes
        nxt_res.eff_addr = {`AMDEC_ZERO8, req.byte1};
        nxt_res.next_pc = req.pc + `AMDEC_PC_THREE +
          (bit_hit ? {{8{req.byte2[7]}}, req.byte2} : 16'h_0000);
      end
      default: begin
        // inherent: no memory operand
        nxt_res.eff_addr = req.pc;
      end
    endcase
    // hold the last result when idle, so res stays stable
    if (!req_valid) begin
      nxt_res = res_ff;
    end
    nxt_res_valid = req_valid;
    // [RULE_07] index passes through unchanged
    nxt_index = req_valid ? req.index : index_ff;
  end

  // result registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      res_ff <= '0;
      res_valid_ff <= 1'b0;
      index_ff <= `AMDEC_ZERO8;
    end else begin
      res_ff <= nxt_res;
      res_valid_ff <= nxt_res_valid;
      index_ff <= nxt_index;
    end
  end

  assign res = res_ff;
  assign res_valid = res_valid_ff;
  assign index_out = index_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_direct_page: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_02]
    req_valid && req.opcode[7:4] == `AMDEC_HI_DIR |=>
      res.eff_addr == {8'h_00, $past(req.byte1)} && res.next_pc == $past(req.pc) + 16'h_0002)
    else $error("direct address wrong");
  a_ext_addr: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_03]
    req_valid && req.opcode[7:4] == `AMDEC_HI_EXT |=>
      res.eff_addr == {$past(req.byte1), $past(req.byte2)} && res.cycles == 4'h_4)
    else $error("extended address wrong");
  a_ix0_addr: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_04]
    req_valid && req.opcode[7:4] == `AMDEC_HI_IX0 |=>
      res.eff_addr[15:8] == 8'h_00 && res.next_pc == $past(req.pc) + 16'h_0001)
    else $error("no-offset index wrong");
  a_ix1_reach: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_05]
    req_valid && req.opcode[7:4] == `AMDEC_HI_IX1 |=>
      res.eff_addr == {8'h_00, $past(req.index)} + {8'h_00, $past(req.byte1)})
    else $error("8-bit offset wrong");
  a_ix2_addr: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_06]
    req_valid && req.opcode[7:4] == `AMDEC_HI_IX2 |=>
      res.eff_addr == {$past(req.byte1), $past(req.byte2)} + {8'h_00, $past(req.index)})
    else $error("16-bit offset wrong");
  a_index_kept: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_07]
    req_valid |=> index_out == $past(req.index))
    else $error("index changed");
  a_rel_not: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_08]
    req_valid && req.opcode[7:4] == `AMDEC_HI_REL && !req.cond_true |=>
      res.next_pc == $past(req.pc) + 16'h_0002)
    else $error("untaken branch wrong");
  a_imm_timing: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_12]
    req_valid && req.opcode[7:4] == `AMDEC_HI_IMM |=> res.cycles == 4'h_2)
    else $error("immediate timing wrong");
  a_tst_nowb: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_15]
    req_valid && req.opcode == 8'h_3D |=> !res.write_back && res.cycles == 4'h_4)
    else $error("test op timing wrong");
  a_rmw_ix1: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_14]
    req_valid && req.opcode == 8'h_6C |=> res.write_back && res.cycles == 4'h_6)
    else $error("modify timing wrong");
  a_store_imm: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_11]
    req_valid && req.opcode == 8'h_A7 |=> res.illegal)
    else $error("store immediate accepted");
  // operand byte sits right after the opcode
  a_imm_operand: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_01]
    req_valid && req.opcode[7:4] == `AMDEC_HI_IMM |=>
      res.eff_addr == $past(req.pc) + 16'h_0001 &&
      res.next_pc == $past(req.pc) + 16'h_0002)
    else $error("immediate operand wrong");
  // extended skips both address bytes
  a_ext_pc: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_03]
    req_valid && req.opcode[7:4] == `AMDEC_HI_EXT |=>
      res.next_pc == $past(req.pc) + 16'h_0003)
    else $error("extended pc wrong");
  // 8-bit offset never leaves the lowest 511 bytes
  a_ix1_pc: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_05]
    req_valid && req.opcode[7:4] == `AMDEC_HI_IX1 |=>
      res.eff_addr[15:9] == 7'h_00 && res.next_pc == $past(req.pc) + 16'h_0002)
    else $error("8-bit offset reach wrong");
  // 16-bit offset instruction is three bytes long
  a_ix2_pc: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_06]
    req_valid && req.opcode[7:4] == `AMDEC_HI_IX2 |=>
      res.next_pc == $past(req.pc) + 16'h_0003)
    else $error("16-bit offset pc wrong");
  // index copy only moves with a new request
  a_index_hold: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_07]
    !req_valid |=> $stable(index_out))
    else $error("index drifted");
  // taken branch lands at pc plus two plus signed offset
  a_rel_taken: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_08]
    req_valid && req.opcode[7:4] == `AMDEC_HI_REL && req.cond_true |=>
      res.next_pc == $past(req.pc) + 16'h_0002 +
        {{8{$past(req.byte1[7])}}, $past(req.byte1)})
    else $error("taken branch wrong");
  // bit set/clear stays in the direct page
  a_bsc_page: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_09]
    req_valid && req.opcode[7:4] == `AMDEC_HI_BSC |=>
      res.eff_addr == {8'h_00, $past(req.byte1)} &&
      res.next_pc == $past(req.pc) + 16'h_0002 &&
      res.bit_num == $past(req.opcode[3:1]))
    else $error("bit set/clear wrong");
  // bit test: selected bit not in the wanted state falls through
  a_btb_miss: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_10]
    req_valid && req.opcode[7:4] == `AMDEC_HI_BTB &&
      req.test_data[req.opcode[3:1]] == req.opcode[0] |=>
      res.next_pc == $past(req.pc) + 16'h_0003)
    else $error("bit test fall-through wrong");
  // bit test: selected bit in the wanted state branches
  a_btb_hit: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_10]
    req_valid && req.opcode[7:4] == `AMDEC_HI_BTB &&
      req.test_data[req.opcode[3:1]] != req.opcode[0] |=>
      res.next_pc == $past(req.pc) + 16'h_0003 +
        {{8{$past(req.byte2[7])}}, $past(req.byte2)})
    else $error("bit test branch wrong");
  // accumulator and index register forms are inherent, three cycles
  a_rmw_inh: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_13]
    req_valid && (req.opcode[7:4] == `AMDEC_HI_RINA ||
      req.opcode[7:4] == `AMDEC_HI_RINX) |=>
      res.mode == AMDEC_M_INH && res.cycles == 4'h_3)
    else $error("inherent modify wrong");
  // direct modify writes back in five cycles
  a_rmw_dir: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_14]
    req_valid && req.opcode == 8'h_3C |=>
      res.mode == AMDEC_M_DIR && res.write_back && res.cycles == 4'h_5)
    else $error("direct modify wrong");
  // scenarios worth seeing at least once
  c_store_imm: cover property (@(posedge core_clk) disable iff (!rst_b)
    req_valid && illegal);
  c_rmw_test: cover property (@(posedge core_clk) disable iff (!rst_b)
    req_valid && req.opcode[7:4] == `AMDEC_HI_RIX1 && req.opcode[3:0] == `AMDEC_LO_TST);
  c_rel_taken: cover property (@(posedge core_clk) disable iff (!rst_b)
    req_valid && req.opcode[7:4] == `AMDEC_HI_REL && req.cond_true);
  c_ix1_carry: cover property (@(posedge core_clk) disable iff (!rst_b)
    req_valid && req.opcode[7:4] == `AMDEC_HI_IX1 && sum_lo[8]);
  c_btb_hit: cover property (@(posedge core_clk) disable iff (!rst_b)
    req_valid && req.opcode[7:4] == `AMDEC_HI_BTB && bit_hit);
endmodule : amdec_top

// ===== bench/amdec_mem.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// program and data memory: bytes after the opcode, direct-page test byte
module amdec_mem (
  input wire logic [15:0] pc,
  output logic [7:0] byte1,
  output logic [7:0] byte2,
  output logic [7:0] test_data
);
  // sparse store, bumped on every load so the read side refreshes
  logic [7:0] mem [logic [15:0]];
  int upd = 0;
  // load one byte
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    mem[a] = d;
    upd++;
  endtask : put
  // unwritten places read the inverted low address byte, a tidy zero only at low byte FF
  function automatic logic [7:0] rd(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : ~a[7:0];
  endfunction : rd
  // operand fetch at pc+1 and pc+2; bit tests read the direct page
  always @(pc, upd) begin
    byte1 = rd(pc + 16'h_0001);
    byte2 = rd(pc + 16'h_0002);
    test_data = rd({8'h_00, byte1});
  end
endmodule : amdec_mem

// ===== bench/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
////////////////////////////////////////////////////////////////////////////////
module tb import amdec_pkg::*;;
  logic core_clk;
  logic rst_b;
  logic req_valid;
  logic [7:0] op_r, idx_r, b1, b2, td;
  logic [15:0] pc_r;
  logic cond_r;
  amdec_req_t req;
  logic res_valid;
  amdec_res_t res;
  logic [7:0] index_out;
  int err_count = 0;
  int compares = 0;
  // request assembled from bench fields and memory bytes
  assign req = '{opcode: op_r, byte1: b1, byte2: b2, index: idx_r, pc: pc_r,
                 cond_true: cond_r, test_data: td};
  amdec_mem i_mem (.pc(pc_r), .byte1(b1), .byte2(b2), .test_data(td));
  amdec_top i_dut (.core_clk(core_clk), .rst_b(rst_b), .req_valid(req_valid),
                   .req(req), .res_valid(res_valid), .res(res), .index_out(index_out));
  // 100 MHz clock
  always #5 core_clk = ~core_clk;
////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic stop_test();
    if (err_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  // one request, result looked at one cycle later
  task automatic issue(input logic [7:0] op, input logic [15:0] pc, input logic [7:0] x,
                       input logic c);
    @(posedge core_clk);
    op_r <= op;
    pc_r <= pc;
    idx_r <= x;
    cond_r <= c;
    req_valid <= 1'b1;
    @(posedge core_clk);
    req_valid <= 1'b0;
    #1;
    `CHK(res_valid, 1'b1)
  endtask : issue
////////////////////////////////////////////////////////////////////////////////
  // immediate, direct and extended forms of load
  task automatic t_abs();
    i_mem.put(16'h_0101, 8'h_40);
    issue(8'h_A6, 16'h_0100, 8'h_00, 1'b0);
    `CHK(res.mode, AMDEC_M_IMM) // imm mode
    `CHK(res.illegal, 1'b0) // load has imm
    `CHK(res.eff_addr, 16'h_0101) // operand next
    `CHK(res.next_pc, 16'h_0102) // imm pc
    `CHK(res.cycles, 4'h_2) // imm cycles
    issue(8'h_B6, 16'h_0100, 8'h_00, 1'b0);
    `CHK(res.eff_addr, 16'h_0040) // direct page
    `CHK(res.next_pc, 16'h_0102) // direct pc
    `CHK(res.cycles, 4'h_3) // direct cycles
    i_mem.put(16'h_2001, 8'h_12);
    i_mem.put(16'h_2002, 8'h_34);
    issue(8'h_C6, 16'h_2000, 8'h_00, 1'b0);
    `CHK(res.eff_addr, 16'h_1234) // byte order
    `CHK(res.next_pc, 16'h_2003) // ext pc
    `CHK(res.cycles, 4'h_4) // ext cycles
  endtask : t_abs
  // indexed forms at carry boundaries
  task automatic t_idx();
    issue(8'h_F6, 16'h_0300, 8'h_FF, 1'b0);
    `CHK(res.eff_addr, 16'h_00FF) // index only
    `CHK(res.next_pc, 16'h_0301) // one byte
    `CHK(res.cycles, 4'h_3) // ix cycles
    i_mem.put(16'h_0301, 8'h_FF);
    issue(8'h_E6, 16'h_0300, 8'h_FF, 1'b0);
    `CHK(res.eff_addr, 16'h_01FE) // top of reach
    `CHK(res.next_pc, 16'h_0302) // ix1 pc
    `CHK(res.cycles, 4'h_4) // ix1 cycles
    `CHK(index_out, 8'h_FF) // index kept
    i_mem.put(16'h_0401, 8'h_12);
    i_mem.put(16'h_0402, 8'h_F0);
    issue(8'h_D6, 16'h_0400, 8'h_20, 1'b0);
    `CHK(res.eff_addr, 16'h_1310) // carry high
    `CHK(res.next_pc, 16'h_0403) // ix2 pc
    `CHK(res.cycles, 4'h_5) // ix2 cycles
    `CHK(index_out, 8'h_20) // index kept
  endtask : t_idx
  // relative branch, both extremes of the offset
  task automatic t_rel();
    i_mem.put(16'h_0101, 8'h_80);
    issue(8'h_20, 16'h_0100, 8'h_00, 1'b1);
    `CHK(res.next_pc, 16'h_0082) // back reach
    issue(8'h_20, 16'h_0100, 8'h_00, 1'b0);
    `CHK(res.next_pc, 16'h_0102) // not taken
    i_mem.put(16'h_0101, 8'h_7F);
    issue(8'h_20, 16'h_0100, 8'h_00, 1'b1);
    `CHK(res.next_pc, 16'h_0181) // fwd reach
  endtask : t_rel
  // bit set/clear and bit test-and-branch
  task automatic t_bit();
    i_mem.put(16'h_0501, 8'h_9A);
    issue(8'h_1D, 16'h_0500, 8'h_00, 1'b0);
    `CHK(res.eff_addr, 16'h_009A) // direct page
    `CHK(res.next_pc, 16'h_0502) // two bytes
    `CHK(res.bit_num, 3'h_6) // bit field
    i_mem.put(16'h_0601, 8'h_30);
    i_mem.put(16'h_0602, 8'h_FE);
    i_mem.put(16'h_0030, 8'h_FB);
    issue(8'h_05, 16'h_0600, 8'h_00, 1'b0);
    `CHK(res.next_pc, 16'h_0601) // clear taken
    `CHK(res.eff_addr, 16'h_0030) // tested byte
    `CHK(res.bit_num, 3'h_2) // bit field
    i_mem.put(16'h_0030, 8'h_04);
    issue(8'h_05, 16'h_0600, 8'h_00, 1'b0);
    `CHK(res.next_pc, 16'h_0603) // not taken
    issue(8'h_04, 16'h_0600, 8'h_00, 1'b0);
    `CHK(res.next_pc, 16'h_0601) // set taken
  endtask : t_bit
  // read/modify/write: every mode, several operations, and the test op
  task automatic t_rmw();
    logic [3:0] hi [5] = '{4'h_4, 4'h_5, 4'h_3, 4'h_7, 4'h_6};
    logic [3:0] cm [5] = '{4'h_3, 4'h_3, 4'h_5, 4'h_5, 4'h_6};
    logic [3:0] ct [5] = '{4'h_3, 4'h_3, 4'h_4, 4'h_4, 4'h_5};
    logic [3:0] lo [4] = '{4'h_0, 4'h_3, 4'h_C, 4'h_F};
    amdec_mode_t md [5] = '{AMDEC_M_INH, AMDEC_M_INH, AMDEC_M_DIR, AMDEC_M_IX0, AMDEC_M_IX1};
    for (int m = 0; m < 5; m++) begin
      for (int k = 0; k < 4; k++) begin
        issue({hi[m], lo[k]}, 16'h_0700, 8'h_10, 1'b0);
        `CHK(res.mode, md[m]) // mode nibble
        `CHK(res.cycles, cm[m]) // modify cycles
        `CHK(res.write_back, 1'b1) // written back
      end
      issue({hi[m], 4'h_D}, 16'h_0700, 8'h_10, 1'b0);
      `CHK(res.mode, md[m]) // test mode
      `CHK(res.cycles, ct[m]) // test cycles
      `CHK(res.write_back, 1'b0) // no write
    end
  endtask : t_rmw
  // store and jump have no immediate form; result then stands
  task automatic t_bad();
    issue(8'h_A7, 16'h_0100, 8'h_00, 1'b0);
    `CHK(res.illegal, 1'b1) // no imm store
    issue(8'h_AC, 16'h_0100, 8'h_00, 1'b0);
    `CHK(res.mode, AMDEC_M_BAD) // no imm jump
    @(posedge core_clk);
    #1;
    `CHK(res_valid, 1'b0)
    `CHK(res.mode, AMDEC_M_BAD) // result stands
  endtask : t_bad
////////////////////////////////////////////////////////////////////////////////
  // watchdog sized well above the run of some 85 cycles
  initial begin
    repeat (3000) @(posedge core_clk);
    err_count++;
    stop_test();
  end
  // main sequence
  initial begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    req_valid = 1'b0;
    op_r = 8'h_00;
    pc_r = 16'h_0000;
    idx_r = 8'h_00;
    cond_r = 1'b0;
    repeat (4) @(posedge core_clk);
    `CHK(res_valid, 1'b0)
    `CHK(index_out, 8'h_00)
    rst_b <= 1'b1;
    t_abs();
    t_idx();
    t_rel();
    t_bit();
    t_rmw();
    t_bad();
    stop_test();
  end
endmodule : tb
